// ### rtl/pced_port_config.sv
// Port drive-mode configuration and three-input edge-detect interrupt unit
// Behaviour
// - Filter select 00/01/10/11 clocks the edge filter at the clock, /2, /4 and /8.
// - Edge input 2 sets the shared flag on falling edges, or on both when its trigger bit is 1.
// - Edge input 1 sets the shared flag on falling edges, or on both when its trigger bit is 1.
// - Edge input 0 sets the shared flag on falling edges, or on both when its trigger bit is 1.
// - Edges on P1.2 only count while the input 2 enable bit is 1.
// - Edges on P1.1 only count while the input 1 enable bit is 1.
// - Edges on P1.0 only count while the input 0 enable bit is 1.
// - The shared edge flag stays set until software clears it by writing a one.
// - Mode bit pairs 00/01/10/11 select quasi, push-pull, input-only and open-drain drive.
// - Port 0 has a mode pair per pin, port 1 for all pins but pin 5; port 2 only for its pins 1 and 0.
// - Per-port Schmitt select bits choose Schmitt input when 1 and TTL when 0.
// - With the timer 1 toggle enabled, P0.7 inverts on each timer 1 overflow.
// - With the timer 0 toggle enabled, P1.2 inverts on each timer 0 overflow.
module pced_port_config (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire pced_pkg::pced_bus_t bus,
    output logic [7:0] rdata,
    input wire pced_pkg::pced_timer_t timer,
    input wire logic [pced_pkg::NUM_PINS-1:0] port_latch,
    input wire logic [pced_pkg::NUM_PINS-1:0] pin_in,
    output logic [pced_pkg::NUM_PINS-1:0] pin_out,
    output logic [pced_pkg::NUM_PINS-1:0] pin_oe_n,
    output logic [pced_pkg::NUM_PINS-1:0] pin_pullup_en,
    output logic [2:0] port_schmitt_select,
    output logic clock_out_enable,
    output logic irq
);
    logic [7:0] edge_ctrl;
    logic [7:0] p0_mode_lo;
    logic [7:0] p0_mode_hi;
    logic [7:0] p1_mode_lo;
    logic [7:0] p1_mode_hi;
    logic [7:0] p2_mode_lo;
    logic [7:0] p2_mode_hi;
    logic shared_edge_flag;
    logic irq_mask;
    logic toggle_p0_7;
    logic toggle_p1_2;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] sample;
    logic [2:0] filt;
    logic [pced_pkg::FILT_CNT_W-1:0] filt_cnt;
    logic [pced_pkg::FILT_CNT_W-1:0] filt_mask;
    logic filt_tick;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [2:0] hit;
    logic edge_event;
    logic flag_clear;
    logic [pced_pkg::NUM_PINS-1:0] mode_m1;
    logic [pced_pkg::NUM_PINS-1:0] mode_m2;
    logic [pced_pkg::NUM_PINS-1:0] pin_data;
    logic [pced_pkg::NUM_PINS-1:0] next_pin_out;
    logic [pced_pkg::NUM_PINS-1:0] next_pin_oe_n;
    logic [pced_pkg::NUM_PINS-1:0] next_pullup;
    logic [7:0] next_rdata;

    // Register writes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            edge_ctrl <= pced_pkg::RST_REG;
            p0_mode_lo <= pced_pkg::RST_REG;
            p0_mode_hi <= pced_pkg::RST_REG;
            p1_mode_lo <= pced_pkg::RST_REG;
            p1_mode_hi <= pced_pkg::RST_REG;
            p2_mode_lo <= pced_pkg::RST_REG;
            p2_mode_hi <= pced_pkg::RST_REG;
            irq_mask <= 1'b0;
        end else if (bus.wr) begin
            case (bus.addr)
                pced_pkg::OFF_EDGE_CTRL: edge_ctrl <= bus.wdata;
                pced_pkg::OFF_P0_MODE_LO: p0_mode_lo <= bus.wdata;
                pced_pkg::OFF_P0_MODE_HI: p0_mode_hi <= bus.wdata;
                pced_pkg::OFF_P1_MODE_LO: begin
                    p1_mode_lo <= bus.wdata & pced_pkg::P1_MODE_WMASK;
                end
                pced_pkg::OFF_P1_MODE_HI: begin
                    p1_mode_hi <= bus.wdata & pced_pkg::P1_MODE_WMASK;
                end
                pced_pkg::OFF_P2_MODE_LO: p2_mode_lo <= bus.wdata;
                pced_pkg::OFF_P2_MODE_HI: begin
                    p2_mode_hi <= bus.wdata & pced_pkg::P2_HI_WMASK;
                end
                pced_pkg::OFF_IRQ_MASK: irq_mask <= bus.wdata[pced_pkg::IRQ_EDGE_BIT];
                default: ;
            endcase
        end
    end

    // Read data, valid the cycle after the strobe; unmapped reads give zero
    always_comb begin
        next_rdata = 8'h00;
        case (bus.addr)
            pced_pkg::OFF_EDGE_CTRL: next_rdata = edge_ctrl;
            pced_pkg::OFF_P0_MODE_LO: next_rdata = p0_mode_lo;
            pced_pkg::OFF_P0_MODE_HI: next_rdata = p0_mode_hi;
            pced_pkg::OFF_P1_MODE_LO: next_rdata = p1_mode_lo;
            pced_pkg::OFF_P1_MODE_HI: next_rdata = p1_mode_hi;
            pced_pkg::OFF_P2_MODE_LO: next_rdata = p2_mode_lo;
            pced_pkg::OFF_P2_MODE_HI: next_rdata = p2_mode_hi;
            pced_pkg::OFF_IRQ_STATUS: next_rdata = {7'h00, shared_edge_flag};
            pced_pkg::OFF_IRQ_MASK: next_rdata = {7'h00, irq_mask};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 8'h00;
        end
    end

    // Filter clock enable from a free-running divider
    always_comb begin
        case (edge_ctrl[pced_pkg::EC_FILT_HI:pced_pkg::EC_FILT_LO])
            2'h0: filt_mask = 3'h0;
            2'h1: filt_mask = 3'h1;
            2'h2: filt_mask = 3'h3;
            default: filt_mask = 3'h7;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            filt_cnt <= '0;
        end else begin
            filt_cnt <= filt_cnt + 3'h1;
        end
    end

    assign filt_tick = (filt_cnt & filt_mask) == 3'h0;

    // Three-flop synchroniser on P1.0..P1.2
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            sync3 <= 3'h7;
        end else begin
            sync1 <= pin_in[pced_pkg::PIN_P1_2:pced_pkg::PIN_P1_0];
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Level accepted only when two successive filter samples agree
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sample <= 3'h7;
            filt <= 3'h7;
        end else if (filt_tick) begin
            for (int i = 0; i < 3; i++) begin
                if (sync2[i] == sync3[i]) begin
                    sample[i] <= sync3[i];
                    if (sample[i] == sync3[i]) begin
                        filt[i] <= sync3[i];
                    end
                end
            end
        end
    end

    always_comb begin
        rise = 3'h0;
        fall = 3'h0;
        if (filt_tick) begin
            for (int i = 0; i < 3; i++) begin
                rise[i] = (sync2[i] == sync3[i]) && (sample[i] == sync3[i])
                          && sync3[i] && !filt[i];
                fall[i] = (sync2[i] == sync3[i]) && (sample[i] == sync3[i])
                          && !sync3[i] && filt[i];
            end
        end
    end

    // Trigger type and enable per edge input
    assign hit[0] = edge_ctrl[pced_pkg::EC_EN0]
                    && (fall[0] || (edge_ctrl[pced_pkg::EC_TRG0] && rise[0]));
    assign hit[1] = edge_ctrl[pced_pkg::EC_EN1]
                    && (fall[1] || (edge_ctrl[pced_pkg::EC_TRG1] && rise[1]));
    assign hit[2] = edge_ctrl[pced_pkg::EC_EN2]
                    && (fall[2] || (edge_ctrl[pced_pkg::EC_TRG2] && rise[2]));
    assign edge_event = |hit;
    assign flag_clear = bus.wr && (bus.addr == pced_pkg::OFF_IRQ_STATUS)
                        && bus.wdata[pced_pkg::IRQ_EDGE_BIT];

    // Sticky flag; a new edge beats a same-cycle clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            shared_edge_flag <= 1'b0;
        end else if (edge_event) begin
            shared_edge_flag <= 1'b1;
        end else if (flag_clear) begin
            shared_edge_flag <= 1'b0;
        end
    end

    assign irq = shared_edge_flag && irq_mask;

    // Timer overflow toggles
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            toggle_p0_7 <= 1'b0;
            toggle_p1_2 <= 1'b0;
        end else begin
            if (timer.ovf1 && p2_mode_lo[pced_pkg::P2_T1_TOGGLE]) begin
                toggle_p0_7 <= !toggle_p0_7;
            end
            if (timer.ovf0 && p2_mode_lo[pced_pkg::P2_T0_TOGGLE]) begin
                toggle_p1_2 <= !toggle_p1_2;
            end
        end
    end

    assign mode_m1 = {p2_mode_lo[1:0], p1_mode_lo, p0_mode_lo};
    assign mode_m2 = {p2_mode_hi[1:0], p1_mode_hi, p0_mode_hi};

    always_comb begin
        pin_data = port_latch;
        if (p2_mode_lo[pced_pkg::P2_T1_TOGGLE]) begin
            pin_data[pced_pkg::PIN_P0_7] = toggle_p0_7;
        end
        if (p2_mode_lo[pced_pkg::P2_T0_TOGGLE]) begin
            pin_data[pced_pkg::PIN_P1_2] = toggle_p1_2;
        end
    end

    // Driver per pin; quasi mode releases a high to the weak pull-up
    always_comb begin
        for (int i = 0; i < pced_pkg::NUM_PINS; i++) begin
            next_pin_out[i] = 1'b0;
            next_pin_oe_n[i] = 1'b1;
            next_pullup[i] = 1'b0;
            case (pced_pkg::pced_mode_t'({mode_m1[i], mode_m2[i]}))
                pced_pkg::PCED_QUASI: begin
                    next_pin_oe_n[i] = pin_data[i];
                    next_pullup[i] = 1'b1;
                end
                pced_pkg::PCED_PUSH_PULL: begin
                    next_pin_out[i] = pin_data[i];
                    next_pin_oe_n[i] = 1'b0;
                end
                pced_pkg::PCED_INPUT_ONLY: next_pin_oe_n[i] = 1'b1;
                pced_pkg::PCED_OPEN_DRAIN: next_pin_oe_n[i] = pin_data[i];
                default: next_pin_oe_n[i] = 1'b1;
            endcase
        end
        // Shared with the reset pin, never driven
        next_pin_oe_n[pced_pkg::PIN_P1_5] = 1'b1;
        next_pullup[pced_pkg::PIN_P1_5] = 1'b0;
        next_pin_out[pced_pkg::PIN_P1_5] = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_out <= '0;
            pin_oe_n <= '1;
            pin_pullup_en <= '0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
            pin_pullup_en <= next_pullup;
        end
    end

    assign port_schmitt_select = {p2_mode_lo[pced_pkg::P2_SCHMITT2],
                                  p2_mode_lo[pced_pkg::P2_SCHMITT1],
                                  p2_mode_lo[pced_pkg::P2_SCHMITT0]};
    assign clock_out_enable = p2_mode_lo[pced_pkg::P2_CLKOUT_EN];

    // Checks
    sequence s_clear_wr;
        flag_clear && !edge_event;
    endsequence

    sequence s_slow_gap;
        !filt_tick [*7] ##1 filt_tick;
    endsequence

    sequence s_mid_gap;
        !filt_tick [*3] ##1 filt_tick;
    endsequence

    sequence s_fast_gap;
        !filt_tick ##1 filt_tick;
    endsequence

    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
        shared_edge_flag && !flag_clear |=> shared_edge_flag)
        else $error("edge flag dropped without clear");

    a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
        edge_event |=> shared_edge_flag && irq == irq_mask)
        else $error("edge event did not set flag");

    a_flag_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_clear_wr |=> !shared_edge_flag)
        else $error("flag not cleared by write one");

    // A new filter setting changes the spacing of the free-running divider mid-count, so a retune abandons the check
    a_filt_div8: assert property (@(posedge ref_clk)
        disable iff (!resetn || (bus.wr && bus.addr == pced_pkg::OFF_EDGE_CTRL))
        filt_tick && edge_ctrl[7:6] == 2'h3 && !bus.wr |=> s_slow_gap)
        else $error("divide by eight filter rate wrong");

    a_filt_div4: assert property (@(posedge ref_clk)
        disable iff (!resetn || (bus.wr && bus.addr == pced_pkg::OFF_EDGE_CTRL))
        filt_tick && edge_ctrl[7:6] == 2'h2 && !bus.wr |=> s_mid_gap)
        else $error("divide by four filter rate wrong");

    a_filt_div2: assert property (@(posedge ref_clk)
        disable iff (!resetn || (bus.wr && bus.addr == pced_pkg::OFF_EDGE_CTRL))
        filt_tick && edge_ctrl[7:6] == 2'h1 && !bus.wr |=> s_fast_gap)
        else $error("divide by two filter rate wrong");

    a_filt_full_rate: assert property (@(posedge ref_clk) disable iff (!resetn)
        edge_ctrl[7:6] == 2'h0 |-> filt_tick)
        else $error("full rate filter missed a tick");

    a_edge_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
        edge_event |-> |(edge_ctrl[4] & fall[2] | edge_ctrl[2] & fall[1]
            | edge_ctrl[0] & fall[0] | edge_ctrl[5] & edge_ctrl[4] & rise[2]
            | edge_ctrl[3] & edge_ctrl[2] & rise[1] | edge_ctrl[1] & edge_ctrl[0] & rise[0]))
        else $error("edge event without enabled cause");

    a_rise_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
        rise[0] && !edge_ctrl[1] && fall[2:1] == 2'h0 && rise[2:1] == 2'h0 |-> !edge_event)
        else $error("rising edge counted in falling mode");

    a_stable_edge: assert property (@(posedge ref_clk) disable iff (!resetn)
        fall[0] |-> $past(sync3[0]) == 1'b0)
        else $error("edge accepted before input stable");

    a_push_pull: assert property (@(posedge ref_clk) disable iff (!resetn)
        mode_m1[0] == 1'b0 && mode_m2[0] == 1'b1
            |=> !pin_oe_n[0] && pin_out[0] == $past(pin_data[0]))
        else $error("push-pull pin not driven");

    a_input_only: assert property (@(posedge ref_clk) disable iff (!resetn)
        mode_m1[1] && !mode_m2[1] |=> pin_oe_n[1])
        else $error("input-only pin driven");

    a_p15_input: assert property (@(posedge ref_clk) disable iff (!resetn)
        pin_oe_n[pced_pkg::PIN_P1_5] && !p1_mode_lo[5] && !p1_mode_hi[5])
        else $error("unimplemented pin bit active");

    a_t1_toggle: assert property (@(posedge ref_clk) disable iff (!resetn)
        timer.ovf1 && p2_mode_lo[3] |=> toggle_p0_7 != $past(toggle_p0_7))
        else $error("P0.7 did not toggle on overflow");

    a_t0_toggle: assert property (@(posedge ref_clk) disable iff (!resetn)
        timer.ovf0 && p2_mode_lo[2] |=> toggle_p1_2 != $past(toggle_p1_2))
        else $error("P1.2 did not toggle on overflow");

    a_read_data: assert property (@(posedge ref_clk) disable iff (!resetn)
        bus.rd && bus.addr == pced_pkg::OFF_P2_MODE_HI |=> rdata[7:2] == 6'h00)
        else $error("port 2 high mode reserved bits read set");

    a_fall2_counted: assert property (@(posedge ref_clk) disable iff (!resetn)
        fall[2] && edge_ctrl[4] |=> shared_edge_flag)
        else $error("enabled falling edge not flagged");

    a_rise0_counted: assert property (@(posedge ref_clk) disable iff (!resetn)
        rise[0] && edge_ctrl[1] && edge_ctrl[0] |=> shared_edge_flag)
        else $error("enabled rising edge not flagged");

    a_en1_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
        (rise[1] || fall[1]) && !edge_ctrl[2] && !hit[0] && !hit[2] |-> !edge_event)
        else $error("disabled input 1 raised an edge");

    a_open_drain: assert property (@(posedge ref_clk) disable iff (!resetn)
        mode_m1[2] && mode_m2[2] |=> pin_oe_n[2] == $past(pin_data[2]) && !pin_pullup_en[2])
        else $error("open-drain pin driven high or pulled up");

    a_p2_reserved: assert property (@(posedge ref_clk) disable iff (!resetn)
        p2_mode_hi[7:2] == 6'h00)
        else $error("port 2 high mode reserved bits set");

endmodule // pced_port_config

// ### shared/pced_pkg.sv
// Package: register map, field positions and carriers for the port config block
package pced_pkg;
    // Register byte addresses on the 8-bit register port
    localparam logic [7:0] OFF_EDGE_CTRL = 8'hA3;
    localparam logic [7:0] OFF_P0_MODE_LO = 8'hB1;
    localparam logic [7:0] OFF_P0_MODE_HI = 8'hB2;
    localparam logic [7:0] OFF_P1_MODE_LO = 8'hB3;
    localparam logic [7:0] OFF_P1_MODE_HI = 8'hB4;
    localparam logic [7:0] OFF_P2_MODE_LO = 8'hB5;
    localparam logic [7:0] OFF_P2_MODE_HI = 8'hB6;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'hA4;
    localparam logic [7:0] OFF_IRQ_MASK = 8'hA5;

    // Edge control fields
    localparam int EC_FILT_HI = 7;
    localparam int EC_FILT_LO = 6;
    localparam int EC_TRG2 = 5;
    localparam int EC_EN2 = 4;
    localparam int EC_TRG1 = 3;
    localparam int EC_EN1 = 2;
    localparam int EC_TRG0 = 1;
    localparam int EC_EN0 = 0;

    // Port 2 low mode register: misc fields
    localparam int P2_SCHMITT2 = 7;
    localparam int P2_SCHMITT1 = 6;
    localparam int P2_SCHMITT0 = 5;
    localparam int P2_CLKOUT_EN = 4;
    localparam int P2_T1_TOGGLE = 3;
    localparam int P2_T0_TOGGLE = 2;

    // Status / mask bit of the shared edge flag
    localparam int IRQ_EDGE_BIT = 0;

    // Flat pin vector: P0 at 0..7, P1 at 8..15, P2 at 16..17
    localparam int NUM_PINS = 18;
    localparam int PIN_P0_7 = 7;
    localparam int PIN_P1_0 = 8;
    localparam int PIN_P1_2 = 10;
    localparam int PIN_P1_5 = 13;
    localparam int P1_UNIMPL_BIT = 5;

    // Reset value and write masks
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] P1_MODE_WMASK = 8'hDF;
    localparam logic [7:0] P2_HI_WMASK = 8'h03;

    // Filter divider
    localparam int FILT_CNT_W = 3;

    typedef enum logic [1:0] {
        PCED_QUASI,
        PCED_PUSH_PULL,
        PCED_INPUT_ONLY,
        PCED_OPEN_DRAIN
    } pced_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pced_bus_t;

    typedef struct packed {
        logic ovf0;
        logic ovf1;
    } pced_timer_t;
endpackage

// ### test/pced_board_model.sv
// Board-side model of the port pins that feeds the device's pin inputs
module pced_board_model (
    input wire logic [pced_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [pced_pkg::NUM_PINS-1:0] pin_oe_n,
    input wire logic [pced_pkg::NUM_PINS-1:0] pin_pullup_en,
    input wire logic [2:0] ext_lvl,
    output logic [pced_pkg::NUM_PINS-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        for (int b = 0; b < pced_pkg::NUM_PINS; b++) begin
            if (!pin_oe_n[b]) begin
                pin_in[b] = pin_out[b];
            end else if (b >= 8 && b <= 10) begin
                // Edge sources are strong drivers, but yield to the device
                pin_in[b] = ext_lvl[b-8];
            end else if (pin_pullup_en[b]) begin
                pin_in[b] = 1'h1;
            end else begin
                // Floating line: never show a stale level
                pin_in[b] = ~pin_out[b];
            end
        end
    end
endmodule // pced_board_model

// ### test/tb_top.sv
// Self-checking testbench for the port configuration and edge-detect block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    pced_pkg::pced_bus_t bus = '0;
    pced_pkg::pced_timer_t timer = '0;
    logic [17:0] port_latch = 18'h3FFFF;
    logic [2:0] ext_lvl = 3'h7;
    logic [7:0] rdata;
    logic [17:0] pin_in;
    logic [17:0] pin_out;
    logic [17:0] pin_oe_n;
    logic [17:0] pin_pullup_en;
    logic [2:0] port_schmitt_select;
    logic clock_out_enable;
    logic irq;
    int n_errors = 0;
    int checks = 0;
    logic [7:0] offs [7] = '{8'hA3, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6};
    logic [7:0] full [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hDF, 8'hDF, 8'hFF, 8'h03};

    always #4 ref_clk = ~ref_clk;

    pced_port_config pced_port_config_i (
        .ref_clk(ref_clk), .resetn(resetn), .bus(bus), .rdata(rdata), .timer(timer),
        .port_latch(port_latch), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup_en(pin_pullup_en), .port_schmitt_select(port_schmitt_select),
        .clock_out_enable(clock_out_enable), .irq(irq));
    pced_board_model pced_board_model_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup_en(pin_pullup_en), .ext_lvl(ext_lvl), .pin_in(pin_in));

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge ref_clk);
        bus <= '0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge ref_clk);
        bus <= '0;
        #1;
        chk({10'h000, rdata}, {10'h000, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic set_ext(input int i, input logic v);
        @(posedge ref_clk);
        ext_lvl[i] <= v;
    endtask
    task automatic pulse(input logic [1:0] t);
        @(posedge ref_clk);
        timer <= t;
        @(posedge ref_clk);
        timer <= '0;
        tick(2);
    endtask
    task automatic set_mode(input logic [1:0] m);
        wr(8'hB1, {8{m[1]}});
        wr(8'hB2, {8{m[0]}});
        wr(8'hB3, {8{m[1]}});
        wr(8'hB4, {8{m[0]}});
        wr(8'hB5, {6'h00, {2{m[1]}}});
        wr(8'hB6, {6'h00, {2{m[0]}}});
    endtask
    task automatic wrap_up();
        $display("checks %0d, n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole run is about a thousand cycles; this leaves wide margin
    initial begin
        #400000;
        n_errors++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        logic [17:0] eo;
        logic [17:0] ep;
        logic [7:0] ctl;
        tick(12);
        resetn <= 1'h1;
        tick(2);
        chk(pin_pullup_en, 18'h3DFFF);
        for (int i = 0; i < 7; i++) begin
            rdchk(offs[i], 8'h00);
            wr(offs[i], 8'hFF);
            rdchk(offs[i], full[i]);
            // Read data stands for one cycle only
            @(posedge ref_clk);
            #1;
            chk({10'h000, rdata}, 18'h00000);
            wr(offs[i], 8'h00);
        end
        wr(8'hC0, 8'hFF);
        rdchk(8'hC0, 8'h00);
        $display("test register access done");

        @(posedge ref_clk);
        port_latch <= 18'h2A50F;
        for (int m = 0; m < 4; m++) begin
            set_mode(m[1:0]);
            tick(2);
            for (int b = 0; b < 18; b++) begin
                case (m)
                    0: {eo[b], ep[b]} = {port_latch[b], 1'h1};
                    1: {eo[b], ep[b]} = 2'h0;
                    2: {eo[b], ep[b]} = 2'h2;
                    default: {eo[b], ep[b]} = {port_latch[b], 1'h0};
                endcase
            end
            eo[13] = 1'h1;
            ep[13] = 1'h0;
            chk(pin_oe_n, eo);
            chk(pin_pullup_en, ep);
            chk(pin_out & ~pin_oe_n, port_latch & ~eo);
        end
        for (int s = 0; s < 8; s++) begin
            wr(8'hB5, {s[2:0], s[0], 4'h0});
            tick(1);
            chk({14'h0000, port_schmitt_select, clock_out_enable},
                {14'h0000, s[2:0], s[0]});
        end
        $display("test pin modes done");

        @(posedge ref_clk);
        port_latch <= '0;
        set_mode(2'h1);
        wr(8'hB5, 8'h0C);
        tick(2);
        for (int k = 0; k < 2; k++) begin
            pulse(2'h1);
            chk({16'h0000, pin_out[10], pin_out[7]}, {16'h0000, k[0], ~k[0]});
            pulse(2'h2);
            chk({16'h0000, pin_out[10], pin_out[7]}, {16'h0000, ~k[0], ~k[0]});
        end
        wr(8'hB5, 8'h00);
        pulse(2'h3);
        chk({16'h0000, pin_out[10], pin_out[7]}, 18'h00000);
        $display("test timer toggle done");

        @(posedge ref_clk);
        port_latch <= 18'h3FFFF;
        set_mode(2'h0);
        wr(8'hA5, 8'h01);
        for (int i = 0; i < 3; i++) begin
            for (int t = 0; t < 2; t++) begin
                ctl = 8'h00;
                ctl[2*i] = 1'h1;
                ctl[2*i+1] = t[0];
                wr(8'hA3, ctl);
                wr(8'hA4, 8'h01);
                set_ext(i, 1'h0);
                tick(15);
                rdchk(8'hA4, 8'h01);
                chk({17'h00000, irq}, 18'h00001);
                wr(8'hA4, 8'h01);
                rdchk(8'hA4, 8'h00);
                set_ext(i, 1'h1);
                tick(15);
                rdchk(8'hA4, {7'h00, t[0]});
                wr(8'hA4, 8'h01);
                // Only a neighbour enabled: this pin must stay silent
                wr(8'hA3, 8'h01 << (2 * ((i + 1) % 3)));
                set_ext(i, 1'h0);
                tick(15);
                set_ext(i, 1'h1);
                tick(15);
                rdchk(8'hA4, 8'h00);
            end
        end
        $display("test edge detect done");

        // Divide by two flags within 7 edges of the change, by four not before 8
        for (int f = 1; f < 3; f++) begin
            wr(8'hA3, {f[1:0], 6'h01});
            wr(8'hA4, 8'h01);
            set_ext(0, 1'h0);
            tick(4);
            rdchk(8'hA4, 8'h00);
            rdchk(8'hA4, {7'h00, f == 1});
            tick(4);
            rdchk(8'hA4, 8'h01);
            set_ext(0, 1'h1);
            tick(20);
        end

        wr(8'hA3, 8'hC1);
        wr(8'hA4, 8'h01);
        set_ext(0, 1'h0);
        tick(1);
        set_ext(0, 1'h1);
        tick(40);
        rdchk(8'hA4, 8'h00);
        set_ext(0, 1'h0);
        tick(6);
        rdchk(8'hA4, 8'h00);
        tick(40);
        rdchk(8'hA4, 8'h01);
        wr(8'hA5, 8'h00);
        tick(1);
        chk({17'h00000, irq}, 18'h00000);
        tick(50);
        rdchk(8'hA4, 8'h01);
        $display("test edge filter done");
        wrap_up();
    end
endmodule // tb_top
